//--- rtl/angle_hold.sv
// Voltage angle hold with AHB-Lite register access
`timescale 1ns/100ps
`include "angle_hold_consts.svh"
module angle_hold import angle_hold_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `PROG_CYCLE_NS / `CLK_PERIOD_NS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire meas_t       meas,
    input  wire logic        block_in,
    output logic             hold_in_use,
    output logic      [15:0] voltage_amp,
    output logic      [15:0] angle_out,
    output logic             unidir_mode,
    output logic      [15:0] sample_freq,
    output logic             irq
);
    logic [6:0]  ctrl_r;
    logic [15:0] vthr_r, ithr_r, tmax_r;
    logic [11:0] evstat_r, evmask_r, evsel_r, evstat_nxt;
    logic [5:0]  lvl_prev_r;
    logic [7:0]  a_addr_r;
    logic        a_wr_r;
    logic        blk_r;
    logic [15:0] angle_pre_r;
    logic [13:0] act_cnt_r;
    logic        tick, blk_sync;
    hold_state_t state_r, state_nxt;

    level_sync u_blk_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       (block_in),
        .q       (blk_sync)
    );

    // Program cycle (5 ms) paces activation, expiry and block sampling
    cycle_divider #(.PERIOD(TICK_CYCLES)) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tick    (tick)
    );

    // Bus decode
    wire        a_phase = hsel && htrans[1] && hready;
    wire [7:0]  a_addr  = haddr[7:0];
    wire        wr_en   = a_wr_r;
    wire        wr_ctrl = wr_en && (a_addr_r == `OFF_CTRL);
    wire        wr_vthr = wr_en && (a_addr_r == `OFF_VTHR);
    wire        wr_ithr = wr_en && (a_addr_r == `OFF_ITHR);
    wire        wr_tmax = wr_en && (a_addr_r == `OFF_TMAX);
    wire        wr_evst = wr_en && (a_addr_r == `OFF_EVSTAT);
    wire        wr_evmk = wr_en && (a_addr_r == `OFF_EVMASK);
    wire        wr_evsl = wr_en && (a_addr_r == `OFF_EVSEL);

    // Setting limits, out-of-range writes saturate
    wire [15:0] vthr_in = hwdata[15:0] < `VTHR_MIN ? `VTHR_MIN :
                          hwdata[15:0] > `VTHR_MAX ? `VTHR_MAX : hwdata[15:0];
    wire [15:0] tmax_in = hwdata[15:0] < `TMAX_MIN ? `TMAX_MIN :
                          hwdata[15:0] > `TMAX_MAX ? `TMAX_MAX : hwdata[15:0];

    // Control fields
    wire        en       = ctrl_r[`CTRL_EN];
    wire        cur_en   = ctrl_r[`CTRL_CUR];
    wire        force_ct = ctrl_r[`CTRL_FORCE_CT];
    wire        f60      = ctrl_r[`CTRL_F60];
    wire        fixed    = ctrl_r[`CTRL_FIXED];
    volt_mode_t mode;
    assign mode = volt_mode_t'(ctrl_r[`CTRL_MODE_HI:`CTRL_MODE_LO]);

    // Channel choice by voltage mode
    wire two_ll  = (mode == two_line_line_mode);
    wire calc_pn = (mode == two_line_plus_residual_mode);
    wire [15:0] v1 = calc_pn ? meas.calc_pn_a : meas.voltage_ch1_rms;
    wire [15:0] v2 = calc_pn ? meas.calc_pn_b : meas.voltage_ch2_rms;
    wire [15:0] v3 = calc_pn ? meas.calc_pn_c : meas.voltage_ch3_rms;
    wire low_v   = (v1 < vthr_r) && (v2 < vthr_r) && (two_ll || v3 < vthr_r);
    wire high_i  = (meas.phase_a_current_rms > ithr_r) ||
                   (meas.phase_b_current_rms > ithr_r) ||
                   (meas.phase_c_current_rms > ithr_r);
    wire act_ok  = en && low_v && (!cur_en || high_i);
    wire ct_trk  = en && force_ct && low_v;

    // Block level used for the whole program cycle
    wire        blk_now   = tick ? blk_sync : blk_r;
    wire [16:0] limit     = {tmax_r, 1'b0};
    wire        time_done = ({3'b000, act_cnt_r} + 17'h00001) >= limit;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_idle: begin
                if (tick && act_ok && !blk_now) begin
                    state_nxt = st_active;
                end
            end
            st_active: begin
                if (!act_ok || blk_now) begin
                    state_nxt = st_idle;
                end else if (tick && time_done) begin
                    state_nxt = st_expired;
                end
            end
            st_expired: begin
                if (!act_ok || blk_now) begin
                    state_nxt = st_idle;
                end
            end
            default: state_nxt = st_idle;
        endcase
        if (!en) begin
            state_nxt = st_idle;
        end
    end

    // Event levels and edges
    wire [5:0]  lvl    = {blk_r, state_r == st_active, ct_trk, high_i && en, low_v && en, en};
    wire [11:0] ev_raw = {~lvl & lvl_prev_r, lvl & ~lvl_prev_r};
    wire [11:0] ev_set = ev_raw & evsel_r;
    wire [11:0] ev_clr = wr_evst ? hwdata[11:0] : 12'h000;
    assign evstat_nxt  = (evstat_r & ~ev_clr) | ev_set;

    wire [31:0] rd_mux =
        (a_addr == `OFF_CTRL)   ? {25'h0000000, ctrl_r} :
        (a_addr == `OFF_VTHR)   ? {16'h0000, vthr_r} :
        (a_addr == `OFF_ITHR)   ? {16'h0000, ithr_r} :
        (a_addr == `OFF_TMAX)   ? {16'h0000, tmax_r} :
        (a_addr == `OFF_STATE)  ? {16'h0000, act_cnt_r[13:0], state_r} :
        (a_addr == `OFF_EVSTAT) ? {20'h00000, evstat_r} :
        (a_addr == `OFF_EVMASK) ? {20'h00000, evmask_r} :
        (a_addr == `OFF_ANGLE)  ? {angle_pre_r, angle_out} :
        (a_addr == `OFF_EVSEL)  ? {20'h00000, evsel_r} : 32'h00000000;

    wire [15:0] freq_nxt = ct_trk ? meas.freq_reference_three :
                           fixed  ? (f60 ? `FREQ_60 : `FREQ_50) :
                           meas.freq_voltage;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_addr_r  <= 8'h00;
            a_wr_r    <= 1'b0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            a_wr_r   <= a_phase && hwrite;
            a_addr_r <= a_phase ? a_addr : a_addr_r;
            if (a_phase && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r   <= 7'h00;
            vthr_r   <= `VTHR_RST;
            ithr_r   <= `ITHR_RST;
            tmax_r   <= `TMAX_RST;
            evmask_r <= 12'h000;
            evsel_r  <= `EVSEL_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= hwdata[6:0];
            if (wr_vthr) vthr_r <= vthr_in;
            if (wr_ithr) ithr_r <= hwdata[15:0];
            if (wr_tmax) tmax_r <= tmax_in;
            if (wr_evmk) evmask_r <= hwdata[11:0];
            if (wr_evsl) evsel_r <= hwdata[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r     <= st_idle;
            blk_r       <= 1'b0;
            act_cnt_r   <= 14'h0000;
            angle_pre_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            blk_r   <= blk_now;
            if (state_nxt != st_active) begin
                act_cnt_r <= 14'h0000;
            end else if (state_r == st_active && tick) begin
                act_cnt_r <= act_cnt_r + 14'h0001;
            end
            // Angle tracks only while healthy, so it is the pre-fault one
            if (state_r == st_idle && !low_v) begin
                angle_pre_r <= meas.angle;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_in_use <= 1'b0;
            voltage_amp <= 16'h0000;
            angle_out   <= 16'h0000;
            unidir_mode <= 1'b0;
            sample_freq <= `FREQ_50;
            lvl_prev_r  <= 6'h00;
            evstat_r    <= 12'h000;
            irq         <= 1'b0;
        end else begin
            hold_in_use <= (state_r == st_active);
            voltage_amp <= (state_r == st_active) ? vthr_r : v1;
            if (state_r != st_active) begin
                angle_out <= angle_pre_r;
            end
            unidir_mode <= (state_r == st_expired);
            sample_freq <= freq_nxt;
            lvl_prev_r  <= lvl;
            evstat_r    <= evstat_nxt;
            irq         <= |(evstat_nxt & evmask_r);
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_off_never_on: assert property (!en |=> state_r == st_idle)
        else $error("hold left active while disabled");
    a_activate_cond: assert property
        (state_r == st_idle && state_nxt == st_active |-> act_ok && tick && !blk_sync)
        else $error("activation without its conditions");
    a_vthr_range: assert property (vthr_r >= `VTHR_MIN && vthr_r <= `VTHR_MAX)
        else $error("threshold out of range");
    a_current_need: assert property
        (state_r == st_idle && tick && en && cur_en && !high_i |=> state_r == st_idle)
        else $error("activated without high current");
    a_amp_subst: assert property (state_r == st_active |=> voltage_amp == $past(vthr_r))
        else $error("amplitude not substituted");
    a_angle_frozen: assert property (hold_in_use && $past(hold_in_use) |-> $stable(angle_out))
        else $error("angle moved while in use");
    a_use_output: assert property ($rose(state_r == st_active) |=> hold_in_use)
        else $error("in-use output missing");
    a_time_limit: assert property (state_r == st_active |-> act_cnt_r < tmax_r * 2)
        else $error("active beyond maximum time");
    a_unidir_after: assert property
        (state_r == st_active && state_nxt == st_expired |=> ##1 unidir_mode)
        else $error("unidirectional mode not raised");
    a_block_held: assert property (!tick |=> $stable(blk_r))
        else $error("block changed mid cycle");
    a_fixed_freq: assert property (en && fixed && !force_ct && !ct_trk |=>
        sample_freq == ($past(f60) ? `FREQ_60 : `FREQ_50))
        else $error("fixed frequency wrong");
    a_ct_track: assert property (ct_trk |=> sample_freq == $past(meas.freq_reference_three))
        else $error("current tracking frequency wrong");
    a_deact_block: assert property (state_r != st_idle && tick && blk_sync |=> state_r == st_idle)
        else $error("block did not end hold");

    c_activate: cover property (state_r == st_idle ##1 state_r == st_active);
    c_expire: cover property (state_r == st_active ##1 state_r == st_expired);
    c_recover: cover property (state_r == st_active && !low_v ##1 state_r == st_idle);
    c_irq: cover property ($rose(irq));
endmodule // angle_hold

//--- rtl/angle_hold_consts.svh
// Constants of the voltage angle hold block
`ifndef ANGLE_HOLD_CONSTS_SVH
`define ANGLE_HOLD_CONSTS_SVH

`define CLK_PERIOD_NS   10
`define PROG_CYCLE_NS   5000000
`define TICKS_PER_UNIT  1

`define OFF_CTRL        8'h00
`define OFF_VTHR        8'h04
`define OFF_ITHR        8'h08
`define OFF_TMAX        8'h0c
`define OFF_STATE       8'h10
`define OFF_EVSTAT      8'h14
`define OFF_EVMASK      8'h18
`define OFF_ANGLE       8'h1c
`define OFF_EVSEL       8'h20

`define CTRL_EN         0
`define CTRL_CUR        1
`define CTRL_FORCE_CT   2
`define CTRL_F60        3
`define CTRL_FIXED      4
`define CTRL_MODE_LO    5
`define CTRL_MODE_HI    6

`define VTHR_MIN        16'h00c8
`define VTHR_MAX        16'h1388
`define VTHR_RST        16'h03e8
`define ITHR_RST        16'h0078
`define TMAX_MIN        16'h0002
`define TMAX_MAX        16'h1388
`define TMAX_RST        16'h0064
`define FREQ_50         16'h1388
`define FREQ_60         16'h1770
`define NUM_EV          6
`define EVSEL_RST       12'hfff

`endif

//--- rtl/angle_hold_pkg.sv
// Types of the voltage angle hold block
package angle_hold_pkg;
    typedef enum logic [1:0] {
        st_idle    = 2'b00,
        st_active  = 2'b01,
        st_expired = 2'b10
    } hold_state_t;

    typedef enum logic [1:0] {
        three_phase_neutral_mode    = 2'b00,
        three_line_line_mode        = 2'b01,
        two_line_line_mode          = 2'b10,
        two_line_plus_residual_mode = 2'b11
    } volt_mode_t;

    typedef struct packed {
        logic [15:0] phase_a_current_rms;
        logic [15:0] phase_b_current_rms;
        logic [15:0] phase_c_current_rms;
        logic [15:0] voltage_ch1_rms;
        logic [15:0] voltage_ch2_rms;
        logic [15:0] voltage_ch3_rms;
        logic [15:0] voltage_ch4_rms;
        logic [15:0] calc_pn_a;
        logic [15:0] calc_pn_b;
        logic [15:0] calc_pn_c;
        logic [15:0] angle;
        logic [15:0] freq_voltage;
        logic [15:0] freq_reference_three;
    } meas_t;
endpackage

//--- rtl/cycle_divider.sv
// Divider giving a one-cycle program-cycle tick
`timescale 1ns/100ps
module cycle_divider #(
    parameter int unsigned PERIOD = 500000
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tick
);
    logic [19:0] cnt_r;
    wire         wrap = (cnt_r == 20'(PERIOD - 1));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 20'h00000;
            tick  <= 1'b0;
        end else begin
            cnt_r <= wrap ? 20'h00000 : cnt_r + 20'h00001;
            tick  <= wrap;
        end
    end
endmodule // cycle_divider

//--- rtl/level_sync.sv
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/100ps
module level_sync (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // level_sync

//--- tb/angle_hold_tb.sv
// Self-checking bench of the voltage angle hold block
`timescale 1ns/100ps
module angle_hold_tb import angle_hold_pkg::*; ;
    localparam int TK = 20;
    localparam logic [15:0] VLO = 16'h0064;
    localparam logic [15:0] VHI = 16'h2710;
    logic        hclk, hresetn, hsel, hwrite, block_in;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, hold_in_use, unidir_mode, irq;
    logic [15:0] voltage_amp, angle_out, sample_freq, v_lvl, v3_lvl, i_lvl, ang;
    meas_t       meas;
    int          bad_count, compares, cyc;

    angle_hold #(.TICK_CYCLES(TK)) angle_hold_i (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .meas(meas), .block_in(block_in), .hold_in_use(hold_in_use),
        .voltage_amp(voltage_amp), .angle_out(angle_out), .unidir_mode(unidir_mode),
        .sample_freq(sample_freq), .irq(irq));
    meas_model #(.UPD(TK)) meas_model_i (.hclk(hclk), .hresetn(hresetn), .v_lvl(v_lvl),
        .v3_lvl(v3_lvl), .i_lvl(i_lvl), .ang(ang), .meas(meas));

    task print_verdict;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // Master holds each phase until hready is seen high; read data taken at that edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    task automatic set_meas(input logic [15:0] v, input logic [15:0] v3, input logic [15:0] i,
                            input logic [15:0] a);
        @(posedge hclk);
        v_lvl  <= v;
        v3_lvl <= v3;
        i_lvl  <= i;
        ang    <= a;
    endtask

    // Bounded wait on hold_in_use (sel 0) or unidir_mode (sel 1)
    task automatic wait_for(input logic sel, input logic e, input int lim);
        logic s;
        int   n;
        n = 0;
        s = ~e;
        while (s !== e && n < lim) begin
            @(posedge hclk);
            #1;
            s = sel ? unidir_mode : hold_in_use;
            n++;
        end
        chk(sel ? "unidir_mode" : "hold_in_use", {31'h0, e}, {31'h0, s});
    endtask

    task t_regs;
        rd_chk("ctrl", 8'h00, 32'h0);
        rd_chk("vthr", 8'h04, 32'h3e8);
        rd_chk("ithr", 8'h08, 32'h78);
        rd_chk("tmax", 8'h0c, 32'h64);
        rd_chk("evmask", 8'h18, 32'h0);
        rd_chk("evsel", 8'h20, 32'hfff);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
        wr(8'h40, 32'hffffffff);
        rd_chk("unmapped", 8'h40, 32'h0);
        wr(8'h04, 32'h1);
        rd_chk("vthr low", 8'h04, 32'hc8);
        wr(8'h04, 32'hffff);
        rd_chk("vthr high", 8'h04, 32'h1388);
        wr(8'h0c, 32'h0);
        rd_chk("tmax low", 8'h0c, 32'h2);
        wr(8'h0c, 32'hffff);
        rd_chk("tmax high", 8'h0c, 32'h1388);
        wr(8'h04, 32'h3e8);
        wr(8'h0c, 32'h64);
    endtask

    task t_off;
        set_meas(VLO, VLO, 16'h10, 16'h1234);
        idle(5 * TK);
        chk("hold disabled", 32'h0, {31'h0, hold_in_use});
        chk("amp disabled", {16'h0, VLO}, {16'h0, voltage_amp});
        wr(8'h00, 32'h1);
        set_meas(VLO, VHI, 16'h10, 16'h1234);
        idle(5 * TK);
        chk("hold one high", 32'h0, {31'h0, hold_in_use});
        wait_for(1'b0, 1'b0, 1);
        wr(8'h00, 32'h41);
        wait_for(1'b0, 1'b1, 4 * TK);
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b0, 3 * TK);
        wr(8'h00, 32'h1);
    endtask

    task t_hold;
        // Earlier scenarios leave sticky events behind; start from a clean status
        wr(8'h14, 32'hfff);
        wr(8'h18, 32'h10);
        idle(3 * TK);
        chk("irq idle", 32'h0, {31'h0, irq});
        set_meas(VLO, VLO, 16'h10, 16'h5555);
        wait_for(1'b0, 1'b1, 4 * TK);
        chk("amp", 32'h3e8, {16'h0, voltage_amp});
        chk("angle", 32'h1234, {16'h0, angle_out});
        idle(3);
        chk("irq set", 32'h1, {31'h0, irq});
        wr(8'h14, 32'hfff);
        idle(3);
        chk("irq clear", 32'h0, {31'h0, irq});
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b0, 3 * TK);
        wr(8'h18, 32'h0);
    endtask

    task t_cur;
        wr(8'h00, 32'h3);
        set_meas(VLO, VLO, 16'h10, 16'h1234);
        idle(5 * TK);
        chk("hold low current", 32'h0, {31'h0, hold_in_use});
        set_meas(VLO, VLO, 16'h100, 16'h1234);
        wait_for(1'b0, 1'b1, 4 * TK);
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b0, 3 * TK);
        wr(8'h00, 32'h1);
    endtask

    task t_exp;
        wr(8'h0c, 32'h2);
        set_meas(VLO, VLO, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b1, 4 * TK);
        idle(2 * TK);
        chk("hold before expiry", 32'h1, {31'h0, hold_in_use});
        wait_for(1'b1, 1'b1, 3 * TK);
        chk("hold expired", 32'h0, {31'h0, hold_in_use});
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b1, 1'b0, 3 * TK);
        wr(8'h0c, 32'h64);
    endtask

    task t_block;
        @(posedge hclk);
        block_in <= 1'b1;
        idle(2 * TK);
        set_meas(VLO, VLO, 16'h10, 16'h1234);
        idle(5 * TK);
        chk("hold blocked", 32'h0, {31'h0, hold_in_use});
        @(posedge hclk);
        block_in <= 1'b0;
        wait_for(1'b0, 1'b1, 4 * TK);
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b0, 3 * TK);
    endtask

    task t_freq;
        wr(8'h00, 32'h19);
        idle(4);
        chk("freq 60", 32'h1770, {16'h0, sample_freq});
        wr(8'h00, 32'h11);
        idle(4);
        chk("freq 50", 32'h1388, {16'h0, sample_freq});
        wr(8'h00, 32'h15);
        set_meas(VLO, VLO, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b1, 4 * TK);
        idle(4);
        chk("freq current", 32'h1200, {16'h0, sample_freq});
        set_meas(VHI, VHI, 16'h10, 16'h1234);
        wait_for(1'b0, 1'b0, 3 * TK);
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // Run is under two thousand cycles; the ceiling is over ten times that
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            print_verdict;
        end
    end

    initial begin
        {hresetn, hsel, hwrite, block_in, htrans} = '0;
        {haddr, hwdata, cyc, bad_count, compares} = '0;
        hsize = 3'b010;
        {v_lvl, v3_lvl, i_lvl, ang} = {VHI, VHI, 16'h10, 16'h1234};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_off;
        t_hold;
        t_cur;
        t_exp;
        t_block;
        t_freq;
        print_verdict;
    end
endmodule // angle_hold_tb

//--- tb/meas_model.sv
// Measurement front end model feeding RMS values to the hold block
`timescale 1ns/100ps
module meas_model import angle_hold_pkg::*; #(
    parameter int unsigned UPD = 20
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic [15:0] v_lvl,
    input  wire logic [15:0] v3_lvl,
    input  wire logic [15:0] i_lvl,
    input  wire logic [15:0] ang,
    output meas_t            meas
);
    int unsigned cnt_r;
    // Values land only on the update boundary, so the block sees stale data in between
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 0;
            meas  <= '0;
        end else begin
            cnt_r <= (cnt_r == UPD - 1) ? 0 : cnt_r + 1;
            if (cnt_r == 0) begin
                meas <= '{i_lvl, i_lvl, i_lvl, v_lvl, v_lvl, v3_lvl, v3_lvl,
                          v_lvl, v_lvl, v_lvl, ang, 16'h1300, 16'h1200};
            end
        end
    end
endmodule // meas_model
